/* File: logic/dofs_top.sv */
// Digital output function select: five outputs, each choosing a
// status condition or a bit of a software word by function code.
// Assumes synchronous status inputs and a one-cycle read-data port.
`timescale 1ns/1ps
module dofs_top
   import dofs_pkg::*;
#(
   parameter int unsigned N_OUT = dofs_pkg::NUM_OUT
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic [dofs_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [dofs_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output      logic [dofs_pkg::DATA_W-1:0]   reg_rdata,
   input  wire dofs_pkg::dofs_alert_t         alert_in,
   input  wire dofs_pkg::dofs_motion_t        motion_in,
   input  wire logic signed [dofs_pkg::POS_W-1:0] position,
   input  wire logic signed [dofs_pkg::VEL_W-1:0] vel_actual,
   input  wire logic signed [dofs_pkg::VEL_W-1:0] vel_target,
   output      logic [N_OUT-1:0]              dout,
   output      logic                          alert_out,
   output      dofs_pkg::dofs_decel_t         decel_out,
   output      logic                          irq
);
   import dofs_pkg::*;

   logic [CODE_W-1:0]       code_ff [N_OUT];
   logic [7:0]              output_force_word_ff;
   logic [POS_W-1:0]        neg_soft_limit_value_ff;
   logic [POS_W-1:0]        pos_soft_limit_value_ff;
   logic [VEL_W-1:0]        velocity_window_ff;
   logic [DATA_W-1:0]       neg_ramp_ff;
   logic [DATA_W-1:0]       pos_ramp_ff;
   logic [IRQ_W-1:0]        irq_stat_ff;
   logic [IRQ_W-1:0]        irq_mask_ff;
   logic [IRQ_W-1:0]        ev_prev_ff;
   logic [N_OUT-1:0]        dout_ff;
   logic                    alert_ff;
   dofs_decel_t             decel_ff;
   logic                    irq_ff;
   logic [DATA_W-1:0]       rdata_ff;

   wire logic               neg_soft_limit_hit;
   wire logic               pos_soft_limit_hit;
   wire logic               velocity_reached;
   wire logic               alert_any;
   wire logic [N_OUT-1:0]   nxt_dout;
   wire logic [IRQ_W-1:0]   ev_now;
   wire logic [IRQ_W-1:0]   ev_rise;
   wire logic [IRQ_W-1:0]   nxt_irq_stat;
   wire logic [IRQ_W-1:0]   stat_clr;
   wire logic               nxt_alert;
   wire dofs_decel_t        nxt_decel;
   wire logic [DATA_W-1:0]  nxt_rdata;
   wire logic [DATA_W-1:0]  code_rd;
   wire logic               code_hit;
   wire logic [ADDR_W-1:0]  code_idx;

   dofs_limit_check #(
      .POS_W (POS_W),
      .VEL_W (VEL_W)
   ) u_limit (
      .position   (position),
      .neg_limit  (neg_soft_limit_value_ff),
      .pos_limit  (pos_soft_limit_value_ff),
      .vel_actual (vel_actual),
      .vel_target (vel_target),
      .vel_window (velocity_window_ff),
      .neg_hit    (neg_soft_limit_hit),
      .pos_hit    (pos_soft_limit_hit),
      .vel_ok     (velocity_reached)
   );

   assign alert_any = alert_in.hw_limit_trip | alert_in.undervoltage
                    | alert_in.node_guard_alert
                    | alert_in.operational_stop_input;

   // Software limit also counts as an alert condition for alert_out, but not in alert_any used by FC_ALERT and status
   assign nxt_alert = alert_any | neg_soft_limit_hit
                    | pos_soft_limit_hit;

   // Negative limit wins if both tripped (misconfigured limits)
   assign nxt_decel.decel_req  = neg_soft_limit_hit
                               | pos_soft_limit_hit;
   assign nxt_decel.decel_ramp = neg_soft_limit_hit ? neg_ramp_ff
                                                    : pos_ramp_ff;

   genvar gi;
   generate
      for (gi = 0; gi < N_OUT; gi++) begin : g_out
         dofs_out_select u_sel (
            .code         (code_ff[gi]),
            .alert        (alert_any),
            .neg_hit      (neg_soft_limit_hit),
            .pos_hit      (pos_soft_limit_hit),
            .record_done  (motion_in.record_done),
            .capture_done (motion_in.capture_one_done),
            .settled      (motion_in.position_settled),
            .vel_ok       (velocity_reached),
            .force_word   (output_force_word_ff),
            .level        (nxt_dout[gi])
         );
      end
   endgenerate

   // Register decode
   assign code_idx = reg_addr >> 2;
   assign code_hit = (reg_addr[1:0] == 2'b00)
                   && (code_idx < ADDR_W'(N_OUT));
   assign code_rd  = code_hit
                   ? DATA_W'(code_ff[code_idx[$clog2(N_OUT)-1:0]])
                   : '0;

   assign ev_now       = {motion_in.capture_one_done,
                          motion_in.record_done,
                          pos_soft_limit_hit,
                          neg_soft_limit_hit};
   assign ev_rise      = ev_now & ~ev_prev_ff;
   assign stat_clr     = (reg_wr && reg_addr == A_IRQ_STAT)
                       ? reg_wdata[IRQ_W-1:0] : '0;
   // A new event beats a simultaneous clear
   assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | ev_rise;

   assign nxt_rdata =
        code_hit                ? code_rd
      : reg_addr == A_FORCE     ? DATA_W'(output_force_word_ff)
      : reg_addr == A_NEG_LIM   ? DATA_W'(neg_soft_limit_value_ff)
      : reg_addr == A_POS_LIM   ? DATA_W'(pos_soft_limit_value_ff)
      : reg_addr == A_VEL_WIN   ? DATA_W'(velocity_window_ff)
      : reg_addr == A_NEG_RAMP  ? neg_ramp_ff
      : reg_addr == A_POS_RAMP  ? pos_ramp_ff
      : reg_addr == A_STATUS    ? DATA_W'({velocity_reached,
                                           pos_soft_limit_hit,
                                           neg_soft_limit_hit,
                                           alert_any})
      : reg_addr == A_IRQ_STAT  ? DATA_W'(irq_stat_ff)
      : reg_addr == A_IRQ_MASK  ? DATA_W'(irq_mask_ff)
      : reg_addr == A_PINS      ? DATA_W'(dout_ff)
      : '0;

   generate
      for (gi = 0; gi < N_OUT; gi++) begin : g_code
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               code_ff[gi] <= CODE_RST;
            end else if (reg_wr && reg_addr == A_CODE0 + ADDR_W'(gi*4)) begin
               code_ff[gi] <= reg_wdata[CODE_W-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_force_word_ff    <= FORCE_RST;
         neg_soft_limit_value_ff <= '0;
         pos_soft_limit_value_ff <= '0;
         velocity_window_ff      <= '0;
         neg_ramp_ff             <= '0;
         pos_ramp_ff             <= '0;
         irq_mask_ff             <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            A_FORCE:    output_force_word_ff <= reg_wdata[7:0];
            A_NEG_LIM:  neg_soft_limit_value_ff <= reg_wdata[POS_W-1:0];
            A_POS_LIM:  pos_soft_limit_value_ff <= reg_wdata[POS_W-1:0];
            A_VEL_WIN:  velocity_window_ff <= reg_wdata[VEL_W-1:0];
            A_NEG_RAMP: neg_ramp_ff <= reg_wdata;
            A_POS_RAMP: pos_ramp_ff <= reg_wdata;
            A_IRQ_MASK: irq_mask_ff <= reg_wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dout_ff     <= '0;
         alert_ff    <= 1'b0;
         decel_ff    <= '0;
         irq_stat_ff <= '0;
         ev_prev_ff  <= '0;
         irq_ff      <= 1'b0;
         rdata_ff    <= '0;
      end else begin
         dout_ff     <= nxt_dout;
         alert_ff    <= nxt_alert;
         decel_ff    <= nxt_decel;
         irq_stat_ff <= nxt_irq_stat;
         ev_prev_ff  <= ev_now;
         irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
         rdata_ff    <= reg_rd ? nxt_rdata : '0;
      end
   end

   assign dout      = dout_ff;
   assign alert_out = alert_ff;
   assign decel_out = decel_ff;
   assign irq       = irq_ff;
   assign reg_rdata = rdata_ff;

   // Assertions per output slot, so whichever slot a test uses is watched
   generate
      for (gi = 0; gi < N_OUT; gi++) begin : g_chk
         chk_force_follow: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (code_ff[gi] >= FC_FORCE_LO && code_ff[gi] <= FC_FORCE_HI)
            |=> dout[gi]
                == $past(output_force_word_ff[code_ff[gi][2:0]]))
            else $error("forced output does not follow word bit");
         chk_alert_sel: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            code_ff[gi] == FC_ALERT |=> dout[gi] == $past(alert_any))
            else $error("alert code output mismatch");
         chk_neg_limit: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (code_ff[gi] == FC_NEG_LIM && $signed(position)
             <= $signed(neg_soft_limit_value_ff)) |=> dout[gi])
            else $error("negative limit not shown");
         chk_pos_limit: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (code_ff[gi] == FC_POS_LIM && $signed(position)
             >= $signed(pos_soft_limit_value_ff)) |=> dout[gi])
            else $error("positive limit not shown");
         chk_record_done: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            code_ff[gi] == FC_REC_DONE
            |=> dout[gi] == $past(motion_in.record_done))
            else $error("record done output mismatch");
         chk_capture_done: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            code_ff[gi] == FC_CAP_DONE
            |=> dout[gi] == $past(motion_in.capture_one_done))
            else $error("capture output mismatch");
         chk_motion_and: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            code_ff[gi] == FC_MOT_DONE
            |=> dout[gi] == $past(motion_in.record_done
                                  && motion_in.position_settled))
            else $error("motion done output mismatch");
         chk_vel_sel: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            code_ff[gi] == FC_VEL_OK
            |=> dout[gi] == $past(velocity_reached))
            else $error("velocity output mismatch");
         chk_reserved_low: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (code_ff[gi] == 6'h12 || code_ff[gi] == 6'h18
             || (code_ff[gi] > FC_VEL_OK && code_ff[gi] < FC_FORCE_LO)
             || code_ff[gi] > FC_FORCE_HI)
            |=> !dout[gi])
            else $error("reserved code drives output");
      end
   endgenerate

   chk_limit_decel: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      neg_soft_limit_hit |=> alert_out && decel_out.decel_req
      && decel_out.decel_ramp == $past(neg_ramp_ff))
      else $error("negative limit decel missing");
   // Positive ramp only when the negative limit is clear
   chk_pos_decel: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      pos_soft_limit_hit && !neg_soft_limit_hit
      |=> alert_out && decel_out.decel_req
      && decel_out.decel_ramp == $past(pos_ramp_ff))
      else $error("positive limit decel missing");

   cov_force_bit: cover property (@(posedge core_clk) disable iff (!rst_n)
      code_ff[0] == FC_FORCE_HI ##1 dout[0]);
   cov_limit_hit: cover property (@(posedge core_clk) disable iff (!rst_n)
      pos_soft_limit_hit ##1 decel_out.decel_req);
   cov_motion_done: cover property (@(posedge core_clk) disable iff (!rst_n)
      code_ff[0] == FC_MOT_DONE ##1 dout[0]);
   cov_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(irq));
endmodule

/* File: common/dofs_pkg.sv */
// Package for the digital output function select block.
// Assumes a single core_clk domain and a plain register port.
package dofs_pkg;
   localparam int unsigned NUM_OUT     = 5;
   localparam int unsigned CODE_W      = 6;
   localparam int unsigned POS_W       = 32;
   localparam int unsigned VEL_W       = 32;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;

   // Function codes
   localparam logic [5:0] FC_ALERT     = 6'h11;
   localparam logic [5:0] FC_NEG_LIM   = 6'h13;
   localparam logic [5:0] FC_POS_LIM   = 6'h14;
   localparam logic [5:0] FC_REC_DONE  = 6'h15;
   localparam logic [5:0] FC_CAP_DONE  = 6'h16;
   localparam logic [5:0] FC_MOT_DONE  = 6'h17;
   localparam logic [5:0] FC_VEL_OK    = 6'h19;
   localparam logic [5:0] FC_FORCE_LO  = 6'h30;
   localparam logic [5:0] FC_FORCE_HI  = 6'h37;

   // Register offsets
   localparam logic [7:0] A_CODE0      = 8'h00;
   localparam logic [7:0] A_FORCE      = 8'h14;
   localparam logic [7:0] A_NEG_LIM    = 8'h18;
   localparam logic [7:0] A_POS_LIM    = 8'h1c;
   localparam logic [7:0] A_VEL_WIN    = 8'h20;
   localparam logic [7:0] A_NEG_RAMP   = 8'h24;
   localparam logic [7:0] A_POS_RAMP   = 8'h28;
   localparam logic [7:0] A_STATUS     = 8'h2c;
   localparam logic [7:0] A_IRQ_STAT   = 8'h30;
   localparam logic [7:0] A_IRQ_MASK   = 8'h34;
   localparam logic [7:0] A_PINS       = 8'h38;

   localparam logic [7:0] FORCE_RST    = 8'h00;
   localparam logic [5:0] CODE_RST     = 6'h00;

   // Interrupt status bit positions
   localparam int unsigned IRQ_W       = 4;
   localparam int unsigned IB_NEG      = 0;
   localparam int unsigned IB_POS      = 1;
   localparam int unsigned IB_REC      = 2;
   localparam int unsigned IB_CAP      = 3;

   typedef struct packed {
      logic hw_limit_trip;
      logic undervoltage;
      logic node_guard_alert;
      logic operational_stop_input;
   } dofs_alert_t;

   typedef struct packed {
      logic record_done;
      logic capture_one_done;
      logic position_settled;
   } dofs_motion_t;

   typedef struct packed {
      logic               decel_req;
      logic [DATA_W-1:0]  decel_ramp;
   } dofs_decel_t;
endpackage

/* File: logic/dofs_limit_check.sv */
// Software limit and velocity window comparators.
// Assumes position and velocities are signed and in core_clk domain.
`timescale 1ns/1ps
module dofs_limit_check #(
   parameter int unsigned POS_W = 32,
   parameter int unsigned VEL_W = 32
) (
   input  wire logic signed [POS_W-1:0] position,
   input  wire logic signed [POS_W-1:0] neg_limit,
   input  wire logic signed [POS_W-1:0] pos_limit,
   input  wire logic signed [VEL_W-1:0] vel_actual,
   input  wire logic signed [VEL_W-1:0] vel_target,
   input  wire logic        [VEL_W-1:0] vel_window,
   output      logic                    neg_hit,
   output      logic                    pos_hit,
   output      logic                    vel_ok
);
   wire logic signed [VEL_W:0] vel_diff;
   wire logic        [VEL_W:0] vel_abs;

   assign neg_hit  = position <= neg_limit;
   assign pos_hit  = position >= pos_limit;
   assign vel_diff = {vel_actual[VEL_W-1], vel_actual}
                   - {vel_target[VEL_W-1], vel_target};
   assign vel_abs  = vel_diff[VEL_W] ? (VEL_W+1)'(0) - vel_diff
                                     : vel_diff;
   // Window is inclusive on both sides
   assign vel_ok   = vel_abs <= {1'b0, vel_window};
endmodule

/* File: logic/dofs_out_select.sv */
// One output's function decode from its code and the status bits.
// Assumes all inputs already registered or synchronous to core_clk.
`timescale 1ns/1ps
module dofs_out_select
   import dofs_pkg::*;
(
   input  wire logic [5:0] code,
   input  wire logic       alert,
   input  wire logic       neg_hit,
   input  wire logic       pos_hit,
   input  wire logic       record_done,
   input  wire logic       capture_done,
   input  wire logic       settled,
   input  wire logic       vel_ok,
   input  wire logic [7:0] force_word,
   output      logic       level
);
   wire logic       in_force;
   wire logic [2:0] force_idx;

   assign in_force  = (code >= FC_FORCE_LO) && (code <= FC_FORCE_HI);
   assign force_idx = code[2:0];

   always_comb begin
      case (code)
         FC_ALERT:    level = alert;
         FC_NEG_LIM:  level = neg_hit;
         FC_POS_LIM:  level = pos_hit;
         FC_REC_DONE: level = record_done;
         FC_CAP_DONE: level = capture_done;
         FC_MOT_DONE: level = record_done & settled;
         FC_VEL_OK:   level = vel_ok;
         default:     level = in_force ? force_word[force_idx]
                                       : 1'b0;
      endcase
   end
endmodule

/* File: verification/dofs_pin_load.sv */
// Model of the machine inputs wired to the digital outputs.
// Assumes the outputs are levels synchronous to core_clk.
`timescale 1ns/1ps
module dofs_pin_load (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic [dofs_pkg::NUM_OUT-1:0] pins,
   output      logic [15:0]                 rise_cnt_ff
);
   import dofs_pkg::*;
   logic prev_ff;
   // Only pin 0 is counted, so a glitch on it shows as an extra rise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff     <= 1'b0;
         rise_cnt_ff <= 16'h0000;
      end else begin
         prev_ff <= pins[0];
         if (pins[0] && !prev_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 16'h0001;
         end
      end
   end
endmodule

/* File: verification/tb_digital_output_function_select.sv */
// Self-checking bench for the output function select block.
// Assumes dofs_top with its plain register port and the pin load model.
`timescale 1ns/1ps
module tb_digital_output_function_select;
   import dofs_pkg::*;
   logic                    core_clk  = 1'b0;
   logic                    rst_n     = 1'b0;
   logic [ADDR_W-1:0]       reg_addr  = '0;
   logic [DATA_W-1:0]       reg_wdata = '0;
   logic                    reg_wr    = 1'b0;
   logic                    reg_rd    = 1'b0;
   logic [DATA_W-1:0]       reg_rdata;
   dofs_alert_t             alert_in  = '0;
   dofs_motion_t            motion_in = '0;
   logic signed [POS_W-1:0] position  = '0;
   logic signed [VEL_W-1:0] vel_act   = '0;
   logic signed [VEL_W-1:0] vel_tgt   = 32'sd1000;
   logic [NUM_OUT-1:0]      dout;
   logic                    alert_out;
   dofs_decel_t             decel_out;
   logic                    irq;
   logic [15:0]             rises;
   logic [31:0]             rdv;
   int                      err_total = 0;
   int                      tests_run = 0;

   dofs_top dut (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .reg_addr   (reg_addr),
      .reg_wdata  (reg_wdata),
      .reg_wr     (reg_wr),
      .reg_rd     (reg_rd),
      .reg_rdata  (reg_rdata),
      .alert_in   (alert_in),
      .motion_in  (motion_in),
      .position   (position),
      .vel_actual (vel_act),
      .vel_target (vel_tgt),
      .dout       (dout),
      .alert_out  (alert_out),
      .decel_out  (decel_out),
      .irq        (irq)
   );

   dofs_pin_load load (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .pins        (dout),
      .rise_cnt_ff (rises)
   );

   always #4 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic set_code(input int i, input logic [5:0] c);
      wr(A_CODE0 + 8'(4 * i), {26'h0, c});
   endtask

   task automatic drive(input dofs_alert_t a, input dofs_motion_t m,
                        input int p, input int v);
      @(posedge core_clk);
      alert_in  <= a;
      motion_in <= m;
      position  <= p;
      vel_act   <= v;
      look(1);
   endtask

   task automatic t_reset();
      rd(A_FORCE, rdv);
      chk(rdv, 32'h0);
      rd(A_CODE0 + 8'h10, rdv);
      chk(rdv, 32'h0);
      chk(32'(dout), 32'h0);
   endtask

   task automatic t_force();
      for (int n = 0; n < 8; n++) begin
         wr(A_FORCE, 32'h0);
         set_code(0, FC_FORCE_LO + 6'(n));
         wr(A_FORCE, 32'h1 << n);
         look(1);
         chk(32'(dout[0]), 32'h1);
         wr(A_FORCE, 32'hff ^ (32'h1 << n));
         look(1);
         chk(32'(dout[0]), 32'h0);
      end
      chk(32'(rises), 32'h8);
      for (int i = 0; i < 5; i++) set_code(i, FC_FORCE_LO + 6'(i));
      wr(A_FORCE, 32'h15);
      look(1);
      chk(32'(dout), 32'h15);
   endtask

   task automatic t_status();
      logic [2:0]  mv [4] = '{3'b100, 3'b001, 3'b101, 3'b000};
      int          vv [4] = '{1006, 994, 1005, 995};
      logic [1:0]  ev [4] = '{2'b00, 2'b00, 2'b11, 2'b10};
      wr(A_FORCE, 32'h0);
      set_code(0, FC_ALERT);
      set_code(1, FC_NEG_LIM);
      set_code(2, FC_POS_LIM);
      set_code(3, FC_REC_DONE);
      set_code(4, FC_CAP_DONE);
      for (int k = 0; k < 4; k++) begin
         drive(4'(1 << k), '0, 0, 1000);
         chk(32'(dout), 32'h01);
      end
      @(posedge core_clk);
      alert_in <= '0;
      @(negedge core_clk);
      chk(32'(dout), 32'h01);
      look(1);
      chk(32'(dout), 32'h00);
      drive('0, '0, -100, 1000);
      chk(32'(dout), 32'h02);
      drive('0, '0, -99, 1000);
      chk(32'(dout), 32'h00);
      drive('0, '0, 99, 1000);
      chk(32'(dout), 32'h00);
      drive('0, '0, 100, 1000);
      chk(32'(dout), 32'h04);
      drive('0, 3'b100, 0, 1000);
      chk(32'(dout), 32'h08);
      drive('0, 3'b010, 0, 1000);
      chk(32'(dout), 32'h10);
      set_code(0, FC_MOT_DONE);
      set_code(1, FC_VEL_OK);
      for (int i = 0; i < 4; i++) begin
         drive('0, mv[i], 0, vv[i]);
         chk(32'(dout[1:0]), 32'(ev[i]));
      end
   endtask

   // All conditions but the positive limit true, so only the code can keep pin 0 low
   task automatic t_reserved();
      logic [5:0] rc [8] = '{6'h00, 6'h10, 6'h12, 6'h18,
                             6'h1a, 6'h2f, 6'h38, 6'h3f};
      wr(A_FORCE, 32'hff);
      set_code(1, FC_FORCE_HI);
      for (int i = 0; i < 8; i++) begin
         set_code(0, rc[i]);
         drive(4'hf, 3'b111, -100, 1000);
         chk(32'(dout[1:0]), 32'h2);
      end
   endtask

   task automatic t_limit();
      drive('0, '0, -100, 1000);
      look(1);
      chk(32'({alert_out, decel_out.decel_req}), 32'h3);
      chk(decel_out.decel_ramp, 32'h1111);
      // Status reads {velocity reached, pos hit, neg hit, alert}
      rd(A_STATUS, rdv);
      chk(rdv, 32'ha);
      // Only slot 1 (force bit 7, word all ones) is high here
      rd(A_PINS, rdv);
      chk(rdv, 32'h2);
      drive('0, '0, 100, 1000);
      look(1);
      chk(32'({alert_out, decel_out.decel_req}), 32'h3);
      chk(decel_out.decel_ramp, 32'h2222);
      drive('0, '0, 0, 1000);
      look(1);
      chk(32'({alert_out, decel_out.decel_req}), 32'h0);
   endtask

   task automatic t_irq();
      wr(A_IRQ_MASK, 32'h0);
      wr(A_IRQ_STAT, 32'hf);
      look(1);
      chk(32'(irq), 32'h0);
      drive('0, '0, -100, 1000);
      look(1);
      rd(A_IRQ_STAT, rdv);
      chk(rdv, 32'h1);
      chk(32'(irq), 32'h0);
      wr(A_IRQ_MASK, 32'h1);
      look(1);
      chk(32'(irq), 32'h1);
      wr(A_IRQ_STAT, 32'h1);
      look(1);
      chk(32'(irq), 32'h0);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, rdv);
      chk(rdv, 32'h0);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      wr(A_NEG_LIM, 32'hffff_ff9c);
      wr(A_POS_LIM, 32'h0000_0064);
      wr(A_VEL_WIN, 32'h0000_0005);
      wr(A_NEG_RAMP, 32'h0000_1111);
      wr(A_POS_RAMP, 32'h0000_2222);
      t_force();
      t_status();
      t_reserved();
      t_limit();
      t_irq();
      wrap_up();
   end

   // About fifty times the expected run length
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end
endmodule
